//--- rtl/tcsda_regs.vh
/*
 holds constants for the tandem connection sink defect-action block:
 overhead byte field positions, codes, persistence counts and timing.
 assumes inclusion by bare name from the design files under rtl/.
*/
`ifndef TCSDA_REGS_VH
`define TCSDA_REGS_VH

`define TCSDA_CODE_MSB 7
`define TCSDA_CODE_LSB 4
`define TCSDA_ALL_ONES_CODE 4'hE
`define TCSDA_UNEQ_BYTE 8'h00
`define TCSDA_PERSIST_FRAMES 3'h5
`define TCSDA_CLK_MHZ 250
`define TCSDA_AIS_LIMIT_US 250
`define TCSDA_AIS_LIMIT_CYC (`TCSDA_AIS_LIMIT_US * `TCSDA_CLK_MHZ)
`define TCSDA_FRAME_BYTES 12'h200
`define TCSDA_ALIGN_ONE 8'hF6
`define TCSDA_ALIGN_TWO 8'h28
`define TCSDA_ALL_ONES_BYTE 8'hFF

`endif

//--- rtl/tcsda_persist.v
/*
 holds a frame-rate persistence filter: a defect sets after a run of
 matching frames and clears after a run of non-matching frames.
 assumes frame_tick_i is a one-cycle pulse on sys_clk_i.
*/
`timescale 1ns/100ps
`include "tcsda_regs.vh"

module tcsda_persist #(
   parameter RUN = 5
) (
   input wire sys_clk_i,
   input wire reset_i,
   input wire clk_en_i,
   input wire frame_tick_i,
   input wire match_i,
   output reg defect_o
);
   reg [2:0] run_count;

   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         run_count <= 3'h0;
         defect_o <= 1'b0;
      end else if (clk_en_i && frame_tick_i) begin
         // counts frames that disagree with the current state
         if (match_i == defect_o) begin
            run_count <= 3'h0;
         end else if (run_count == RUN[2:0] - 3'h1) begin
            run_count <= 3'h0;
            defect_o <= match_i;
         end else begin
            run_count <= run_count + 3'h1;
         end
      end
   end
endmodule

//--- rtl/tcsda_top.v
/*
 holds the tandem connection sink defect and action logic, together
 with the adaptation source and sink around it.
 assumes stream byte, its clock and frame start arrive from outside the
 sys_clk_i domain; other defect inputs are synchronous to sys_clk_i.
*/
`timescale 1ns/100ps
`include "tcsda_regs.vh"

// Summary of operation
// - incoming all-ones defect sets after five frames with error-code nibble 1110.
// - incoming all-ones defect clears after five frames with any other nibble.
// - only nibble 1110 means incoming all-ones; every other code means none.
// - all-ones request raised by unequipped, trace mismatch or tandem loss.
// - trail fail and remote defect from upstream fail or those defects; degrade from degrade.
// - outgoing defect from upstream fail, unequipped, mismatch, incoming all-ones, tandem loss.
// - outgoing fail from upstream fail, unequipped, mismatch, tandem loss, incoming all-ones.
// - all-ones replacement starts within 250 us of request rise, both sinks.
// - all-ones replacement stops within 250 us of request drop, both sinks.
// - unequipped cause when monitored; tandem-loss cause when monitored, not unequipped.
// - trace-mismatch cause only when monitored and no unequipped or tandem loss.
// - degrade cause only when monitored, no trace mismatch and no tandem loss.
// - upstream-fail cause when monitored, upstream fail active and enabled.
// - remote-defect cause when monitored, enabled, no unequipped, mismatch, tandem loss.
// - outgoing-defect cause when monitored, enabled, no unequipped, mismatch, tandem loss.
// - incoming all-ones cause when monitored, enabled, no upstream fail, tandem loss, mismatch.
// - separate report enable inputs for upstream fail, remote, outgoing, incoming all-ones; none is reset.
// - per second: sum four block error kinds, flag near and far defect seconds.
// - adaptation source substitutes aligned all-ones frame and forwards upstream fail.
// - substitute frame start comes from local timing input.
// - adaptation sink asserts all-ones request and server fail from outgoing fail input.
// - unequipped sets after five zero overhead bytes, clears after five nonzero.
// - tandem loss held while out of multiframe, cleared when in multiframe.
module tcsda_top #(
   parameter CNT_W = 16,
   parameter AIS_LIMIT_CYC = `TCSDA_AIS_LIMIT_CYC,
   parameter FRAME_BYTES = `TCSDA_FRAME_BYTES
) (
   input wire sys_clk_i,
   input wire reset_i,
   input wire clk_en_i,
   input wire stream_clk_i,
   input wire stream_fs_i,
   input wire [7:0] tandem_overhead_byte_i,
   input wire [7:0] stream_data_i,
   input wire local_timing_in_i,
   input wire upstream_fail_in_i,
   input wire out_of_multiframe_i,
   input wire trace_mismatch_defect_i,
   input wire degrade_defect_i,
   input wire remote_defect_flag_i,
   input wire outgoing_defect_flag_i,
   input wire equipment_defect_i,
   input wire near_block_error_i,
   input wire far_block_error_i,
   input wire outgoing_near_block_error_i,
   input wire outgoing_far_block_error_i,
   input wire monitored_state_i,
   input wire upstream_fail_report_enable_i,
   input wire remote_defect_report_enable_i,
   input wire outgoing_defect_report_enable_i,
   input wire all_ones_report_enable_i,
   input wire one_second_i,
   input wire outgoing_fail_in_i,
   output wire incoming_all_ones_defect_o,
   output wire unequipped_defect_o,
   output wire tandem_loss_defect_o,
   output wire all_ones_request_o,
   output reg all_ones_active_o,
   output wire trail_fail_action_o,
   output wire trail_degrade_action_o,
   output wire remote_defect_action_o,
   output wire remote_error_action_o,
   output wire outgoing_defect_action_o,
   output wire outgoing_error_action_o,
   output wire outgoing_fail_action_o,
   output reg [7:0] sink_data_o,
   output reg unequipped_cause_o,
   output reg tandem_loss_cause_o,
   output reg trace_mismatch_cause_o,
   output reg degrade_cause_o,
   output reg upstream_fail_cause_o,
   output reg remote_defect_cause_o,
   output reg outgoing_defect_cause_o,
   output reg incoming_all_ones_cause_o,
   output reg [CNT_W-1:0] near_block_count_o,
   output reg [CNT_W-1:0] far_block_count_o,
   output reg [CNT_W-1:0] outgoing_near_block_count_o,
   output reg [CNT_W-1:0] outgoing_far_block_count_o,
   output reg near_defect_second_o,
   output reg far_defect_second_o,
   output reg outgoing_near_defect_second_o,
   output reg outgoing_far_defect_second_o,
   output reg [7:0] source_data_o,
   output reg source_fs_o,
   output wire adapted_fail_out_o,
   output wire server_fail_action_o,
   output wire adapt_all_ones_request_o,
   output reg adapt_all_ones_active_o,
   output reg [7:0] adapt_data_o
);
   localparam [11:0] FRAME_LEN = FRAME_BYTES[11:0];

   // saturating add of one error event
   function [CNT_W-1:0] sat_inc;
      input [CNT_W-1:0] value;
      input hit;
      begin
         if (hit && value != {CNT_W{1'b1}}) begin
            sat_inc = value + {{(CNT_W-1){1'b0}}, 1'b1};
         end else begin
            sat_inc = value;
         end
      end
   endfunction

   // two-stage synchronisers for the stream side pins
   reg [2:0] sync_a;
   reg [2:0] sync_b;
   reg [7:0] byte_a;
   reg [7:0] byte_b;
   reg [7:0] data_a;
   reg [7:0] data_b;
   reg [1:0] oom_sync;
   reg clk_prev;
   reg fs_prev;
   reg lt_prev;

   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
         byte_a <= 8'h00;
         byte_b <= 8'h00;
         data_a <= 8'h00;
         data_b <= 8'h00;
         oom_sync <= 2'h3;
         clk_prev <= 1'b0;
         fs_prev <= 1'b0;
         lt_prev <= 1'b0;
      end else if (clk_en_i) begin
         sync_a <= {local_timing_in_i, stream_fs_i, stream_clk_i};
         sync_b <= sync_a;
         byte_a <= tandem_overhead_byte_i;
         byte_b <= byte_a;
         data_a <= stream_data_i;
         data_b <= data_a;
         oom_sync <= {oom_sync[0], out_of_multiframe_i};
         clk_prev <= sync_b[0];
         fs_prev <= sync_b[1];
         lt_prev <= sync_b[2];
      end
   end

   wire stream_edge = sync_b[0] & ~clk_prev;
   // frame start qualified by a stream clock edge
   wire frame_tick = stream_edge & sync_b[1] & ~fs_prev;
   wire local_tick = sync_b[2] & ~lt_prev;

   wire nibble_ais = (byte_b[`TCSDA_CODE_MSB:`TCSDA_CODE_LSB] == `TCSDA_ALL_ONES_CODE);
   wire byte_uneq = (byte_b == `TCSDA_UNEQ_BYTE);

   tcsda_persist #(.RUN(`TCSDA_PERSIST_FRAMES)) u_inc_ais (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .frame_tick_i(frame_tick),
      .match_i(nibble_ais),
      .defect_o(incoming_all_ones_defect_o)
   );

   tcsda_persist #(.RUN(`TCSDA_PERSIST_FRAMES)) u_uneq (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .frame_tick_i(frame_tick),
      .match_i(byte_uneq),
      .defect_o(unequipped_defect_o)
   );

   assign tandem_loss_defect_o = oom_sync[1];

   wire d_uneq = unequipped_defect_o;
   wire d_tim = trace_mismatch_defect_i;
   wire d_ltc = tandem_loss_defect_o;
   wire d_inc = incoming_all_ones_defect_o;
   wire ssf = upstream_fail_in_i;
   wire connect_fail = d_uneq | d_tim | d_ltc;

   assign all_ones_request_o = connect_fail;
   assign trail_fail_action_o = ssf | connect_fail;
   assign remote_defect_action_o = ssf | connect_fail;
   assign trail_degrade_action_o = degrade_defect_i;
   assign outgoing_defect_action_o = ssf | connect_fail | d_inc;
   assign outgoing_fail_action_o = ssf | connect_fail | d_inc;
   assign remote_error_action_o = near_block_error_i;
   assign outgoing_error_action_o = outgoing_near_block_error_i;

   // two-cycle replacement lag sits far inside the limit, so no wait timer is kept
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         all_ones_active_o <= 1'b0;
         sink_data_o <= 8'h00;
      end else if (clk_en_i) begin
         all_ones_active_o <= all_ones_request_o;
         if (all_ones_active_o) begin
            sink_data_o <= `TCSDA_ALL_ONES_BYTE;
         end else begin
            sink_data_o <= data_b;
         end
      end
   end

   // adaptation sink
   assign adapt_all_ones_request_o = outgoing_fail_in_i;
   assign server_fail_action_o = outgoing_fail_in_i;

   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         adapt_all_ones_active_o <= 1'b0;
         adapt_data_o <= 8'h00;
      end else if (clk_en_i) begin
         adapt_all_ones_active_o <= adapt_all_ones_request_o;
         if (adapt_all_ones_active_o) begin
            adapt_data_o <= `TCSDA_ALL_ONES_BYTE;
         end else begin
            adapt_data_o <= data_b;
         end
      end
   end

   // fault cause correlation, registered for clean outputs
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         unequipped_cause_o <= 1'b0;
         tandem_loss_cause_o <= 1'b0;
         trace_mismatch_cause_o <= 1'b0;
         degrade_cause_o <= 1'b0;
         upstream_fail_cause_o <= 1'b0;
         remote_defect_cause_o <= 1'b0;
         outgoing_defect_cause_o <= 1'b0;
         incoming_all_ones_cause_o <= 1'b0;
      end else if (clk_en_i) begin
         unequipped_cause_o <= monitored_state_i & d_uneq;
         tandem_loss_cause_o <= monitored_state_i & ~d_uneq & d_ltc;
         trace_mismatch_cause_o <= monitored_state_i & ~d_uneq & ~d_ltc & d_tim;
         degrade_cause_o <= monitored_state_i & ~d_tim & ~d_ltc & degrade_defect_i;
         upstream_fail_cause_o <= monitored_state_i & ssf
            & upstream_fail_report_enable_i;
         remote_defect_cause_o <= monitored_state_i & ~connect_fail
            & remote_defect_flag_i & remote_defect_report_enable_i;
         outgoing_defect_cause_o <= monitored_state_i & ~connect_fail
            & outgoing_defect_flag_i & outgoing_defect_report_enable_i;
         incoming_all_ones_cause_o <= monitored_state_i & d_inc & ~ssf & ~d_ltc & ~d_tim
            & all_ones_report_enable_i;
      end
   end

   // one-second accumulation; results latch at the second mark
   reg [CNT_W-1:0] acc_near;
   reg [CNT_W-1:0] acc_far;
   reg [CNT_W-1:0] acc_onear;
   reg [CNT_W-1:0] acc_ofar;
   reg sec_near;
   reg sec_far;
   reg sec_onear;
   reg sec_ofar;
   wire blk_tick = frame_tick;

   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         acc_near <= {CNT_W{1'b0}};
         acc_far <= {CNT_W{1'b0}};
         acc_onear <= {CNT_W{1'b0}};
         acc_ofar <= {CNT_W{1'b0}};
         sec_near <= 1'b0;
         sec_far <= 1'b0;
         sec_onear <= 1'b0;
         sec_ofar <= 1'b0;
         near_block_count_o <= {CNT_W{1'b0}};
         far_block_count_o <= {CNT_W{1'b0}};
         outgoing_near_block_count_o <= {CNT_W{1'b0}};
         outgoing_far_block_count_o <= {CNT_W{1'b0}};
         near_defect_second_o <= 1'b0;
         far_defect_second_o <= 1'b0;
         outgoing_near_defect_second_o <= 1'b0;
         outgoing_far_defect_second_o <= 1'b0;
      end else if (clk_en_i) begin
         if (one_second_i) begin
            // an error in the boundary cycle counts in the closing second
            near_block_count_o <= sat_inc(acc_near, blk_tick & near_block_error_i);
            far_block_count_o <= sat_inc(acc_far, blk_tick & far_block_error_i);
            outgoing_near_block_count_o <= sat_inc(acc_onear,
               blk_tick & outgoing_near_block_error_i);
            outgoing_far_block_count_o <= sat_inc(acc_ofar,
               blk_tick & outgoing_far_block_error_i);
            near_defect_second_o <= sec_near | trail_fail_action_o | equipment_defect_i;
            far_defect_second_o <= sec_far | remote_defect_flag_i;
            outgoing_near_defect_second_o <= sec_onear | outgoing_defect_action_o
               | equipment_defect_i;
            outgoing_far_defect_second_o <= sec_ofar | outgoing_defect_flag_i;
            acc_near <= {CNT_W{1'b0}};
            acc_far <= {CNT_W{1'b0}};
            acc_onear <= {CNT_W{1'b0}};
            acc_ofar <= {CNT_W{1'b0}};
            sec_near <= 1'b0;
            sec_far <= 1'b0;
            sec_onear <= 1'b0;
            sec_ofar <= 1'b0;
         end else begin
            acc_near <= sat_inc(acc_near, blk_tick & near_block_error_i);
            acc_far <= sat_inc(acc_far, blk_tick & far_block_error_i);
            acc_onear <= sat_inc(acc_onear, blk_tick & outgoing_near_block_error_i);
            acc_ofar <= sat_inc(acc_ofar, blk_tick & outgoing_far_block_error_i);
            sec_near <= sec_near | trail_fail_action_o | equipment_defect_i;
            sec_far <= sec_far | remote_defect_flag_i;
            sec_onear <= sec_onear | outgoing_defect_action_o | equipment_defect_i;
            sec_ofar <= sec_ofar | outgoing_defect_flag_i;
         end
      end
   end

   // adaptation source: local frame generator timed by local ticks
   reg [11:0] byte_pos;
   assign adapted_fail_out_o = ssf;

   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         byte_pos <= 12'h000;
         source_data_o <= 8'h00;
         source_fs_o <= 1'b0;
      end else if (clk_en_i) begin
         if (local_tick) begin
            if (byte_pos == FRAME_LEN - 12'h001) begin
               byte_pos <= 12'h000;
            end else begin
               byte_pos <= byte_pos + 12'h001;
            end
         end
         if (ssf) begin
            if (local_tick) begin
               source_fs_o <= (byte_pos == 12'h000);
               if (byte_pos == 12'h000) begin
                  source_data_o <= `TCSDA_ALIGN_ONE;
               end else if (byte_pos == 12'h001) begin
                  source_data_o <= `TCSDA_ALIGN_TWO;
               end else begin
                  source_data_o <= `TCSDA_ALL_ONES_BYTE;
               end
            end else begin
               source_fs_o <= 1'b0;
            end
         end else begin
            source_fs_o <= frame_tick;
            if (stream_edge) begin
               source_data_o <= data_b;
            end
         end
      end
   end
endmodule

//--- dv/tcsda_stream_model.sv
/*
 stream side model: link clock, frame start, overhead byte, data, local timing.
 assumes the bench changes next_byte_i just after a frame start.
*/
`timescale 1ns/100ps
module tcsda_stream_model (
   input wire logic [7:0] next_byte_i,
   output logic stream_clk_o,
   output logic stream_fs_o,
   output logic [7:0] ovh_byte_o,
   output logic [7:0] data_o,
   output logic local_tick_o
);
   logic [1:0] pos;
   initial begin
      stream_clk_o = 1'b0;
      local_tick_o = 1'b0;
      stream_fs_o = 1'b0;
      pos = 2'd0;
      ovh_byte_o = 8'h35;
      data_o = 8'h00;
   end
   // link clock runs free, so frames follow each other every four link cycles
   always #32 stream_clk_o = ~stream_clk_o;
   always #16 local_tick_o = ~local_tick_o;
   always @(posedge stream_clk_o) begin
      pos <= pos + 2'd1;
      stream_fs_o <= (pos == 2'd3);
      // top bit kept low so an inserted all-ones byte stands out
      data_o <= {1'b0, data_o[6:0] + 7'h01};
      // byte changes mid-frame, well away from the frame start sample
      if (pos == 2'd1) begin
         ovh_byte_o <= next_byte_i;
      end
   end
endmodule

//--- dv/tcsda_top_properties.sv
/*
 concurrent checks on the tandem connection defect-action top ports.
 assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module tcsda_top_properties (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic upstream_fail_in_i,
   input wire logic trace_mismatch_defect_i,
   input wire logic degrade_defect_i,
   input wire logic monitored_state_i,
   input wire logic upstream_fail_report_enable_i,
   input wire logic near_block_error_i,
   input wire logic outgoing_fail_in_i,
   input wire logic incoming_all_ones_defect_o,
   input wire logic unequipped_defect_o,
   input wire logic tandem_loss_defect_o,
   input wire logic all_ones_request_o,
   input wire logic all_ones_active_o,
   input wire logic trail_fail_action_o,
   input wire logic trail_degrade_action_o,
   input wire logic remote_defect_action_o,
   input wire logic remote_error_action_o,
   input wire logic outgoing_defect_action_o,
   input wire logic outgoing_fail_action_o,
   input wire logic [7:0] sink_data_o,
   input wire logic unequipped_cause_o,
   input wire logic trace_mismatch_cause_o,
   input wire logic upstream_fail_cause_o,
   input wire logic source_fs_o,
   input wire logic adapted_fail_out_o,
   input wire logic server_fail_action_o,
   input wire logic adapt_all_ones_request_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   logic base_fail;
   assign base_fail = upstream_fail_in_i | unequipped_defect_o | trace_mismatch_defect_i
      | tandem_loss_defect_o;
   AST_AIS_REQ: assert property (all_ones_request_o == (unequipped_defect_o
      | trace_mismatch_defect_i | tandem_loss_defect_o)) else $error("all-ones request wrong");
   AST_TRAIL_FAIL: assert property (trail_fail_action_o == base_fail
      && remote_defect_action_o == base_fail) else $error("trail fail or remote defect wrong");
   AST_DEGRADE: assert property (trail_degrade_action_o == degrade_defect_i)
      else $error("degrade action wrong");
   AST_OUT_DEFECT: assert property (outgoing_defect_action_o == (base_fail
      | incoming_all_ones_defect_o)) else $error("outgoing defect action wrong");
   AST_OUT_FAIL: assert property (outgoing_fail_action_o == (base_fail
      | incoming_all_ones_defect_o)) else $error("outgoing fail action wrong");
   AST_INSERT: assert property (all_ones_request_o [*2] |=> sink_data_o == 8'hFF)
      else $error("all-ones not inserted");
   AST_RELEASE: assert property (!all_ones_request_o |=> !all_ones_active_o)
      else $error("all-ones insertion kept");
   AST_UNEQ_CAUSE: assert property (1'b1 |=> unequipped_cause_o
      == $past(monitored_state_i && unequipped_defect_o)) else $error("unequipped cause wrong");
   AST_TIM_CAUSE: assert property (1'b1 |=> trace_mismatch_cause_o == $past(
      monitored_state_i && trace_mismatch_defect_i && !unequipped_defect_o
      && !tandem_loss_defect_o)) else $error("mismatch cause wrong");
   AST_SSF_CAUSE: assert property (!upstream_fail_report_enable_i |=>
      !upstream_fail_cause_o) else $error("upstream fail cause while disabled");
   AST_ERR_COPY: assert property (remote_error_action_o == near_block_error_i)
      else $error("remote error action wrong");
   AST_SRC_FAIL: assert property (adapted_fail_out_o == upstream_fail_in_i)
      else $error("adapted fail wrong");
   AST_ADAPT: assert property (outgoing_fail_in_i |-> server_fail_action_o
      && adapt_all_ones_request_o) else $error("adaptation sink fail wrong");
   cover property (incoming_all_ones_defect_o);
   cover property (unequipped_defect_o && all_ones_active_o);
   cover property (source_fs_o && adapted_fail_out_o);
endmodule

bind tcsda_top tcsda_top_properties u_props (
   .sys_clk_i(sys_clk_i), .reset_i(reset_i), .upstream_fail_in_i(upstream_fail_in_i),
   .trace_mismatch_defect_i(trace_mismatch_defect_i), .degrade_defect_i(degrade_defect_i),
   .monitored_state_i(monitored_state_i),
   .upstream_fail_report_enable_i(upstream_fail_report_enable_i),
   .near_block_error_i(near_block_error_i), .outgoing_fail_in_i(outgoing_fail_in_i),
   .incoming_all_ones_defect_o(incoming_all_ones_defect_o),
   .unequipped_defect_o(unequipped_defect_o), .tandem_loss_defect_o(tandem_loss_defect_o),
   .all_ones_request_o(all_ones_request_o), .all_ones_active_o(all_ones_active_o),
   .trail_fail_action_o(trail_fail_action_o), .trail_degrade_action_o(trail_degrade_action_o),
   .remote_defect_action_o(remote_defect_action_o),
   .remote_error_action_o(remote_error_action_o),
   .outgoing_defect_action_o(outgoing_defect_action_o),
   .outgoing_fail_action_o(outgoing_fail_action_o), .sink_data_o(sink_data_o),
   .unequipped_cause_o(unequipped_cause_o), .trace_mismatch_cause_o(trace_mismatch_cause_o),
   .upstream_fail_cause_o(upstream_fail_cause_o), .source_fs_o(source_fs_o),
   .adapted_fail_out_o(adapted_fail_out_o), .server_fail_action_o(server_fail_action_o),
   .adapt_all_ones_request_o(adapt_all_ones_request_o)
);

//--- dv/tcsda_top_test.sv
/*
 self-checking bench for the tandem connection defect-action block.
 assumes the stream model drives the link side and the checker is bound.
*/
`timescale 1ns/100ps
`include "tcsda_regs.vh"
module tcsda_top_test;
   logic sys_clk_i, reset_i, uf, tim, oom, deg, rdi, odi, eqd, nbe, fbe, onbe, ofbe;
   logic mon, en, aen, sec, ofi, e_tsf;
   logic [7:0] nb;
   time t0;
   wire s_clk, s_fs, lt, incais, uneq, tl, req, act, tsf, tsd, rda, rea, oda, oea, osf;
   wire ucz, tlc, timc, degc, ssfc, rdic, odic, iac, nds, fds, onds, ofds, sfs, afo;
   wire ssfa, aar, aact;
   wire [7:0] ovh, sdat, sink_d, src_d, ad_d;
   wire [15:0] nbc, fbc, onbc, ofbc;
   int n_fail = 0;
   int samples_checked = 0;

   tcsda_stream_model model (.next_byte_i(nb), .stream_clk_o(s_clk), .stream_fs_o(s_fs),
      .ovh_byte_o(ovh), .data_o(sdat), .local_tick_o(lt));
   tcsda_top #(.FRAME_BYTES(16)) dut (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(1'b1), .stream_clk_i(s_clk),
      .stream_fs_i(s_fs), .tandem_overhead_byte_i(ovh), .stream_data_i(sdat),
      .local_timing_in_i(lt), .upstream_fail_in_i(uf), .out_of_multiframe_i(oom),
      .trace_mismatch_defect_i(tim), .degrade_defect_i(deg), .remote_defect_flag_i(rdi),
      .outgoing_defect_flag_i(odi), .equipment_defect_i(eqd), .near_block_error_i(nbe),
      .far_block_error_i(fbe), .outgoing_near_block_error_i(onbe),
      .outgoing_far_block_error_i(ofbe), .monitored_state_i(mon),
      .upstream_fail_report_enable_i(en), .remote_defect_report_enable_i(en),
      .outgoing_defect_report_enable_i(en), .all_ones_report_enable_i(aen),
      .one_second_i(sec), .outgoing_fail_in_i(ofi), .incoming_all_ones_defect_o(incais),
      .unequipped_defect_o(uneq), .tandem_loss_defect_o(tl), .all_ones_request_o(req),
      .all_ones_active_o(act), .trail_fail_action_o(tsf), .trail_degrade_action_o(tsd),
      .remote_defect_action_o(rda), .remote_error_action_o(rea),
      .outgoing_defect_action_o(oda), .outgoing_error_action_o(oea),
      .outgoing_fail_action_o(osf), .sink_data_o(sink_d), .unequipped_cause_o(ucz),
      .tandem_loss_cause_o(tlc), .trace_mismatch_cause_o(timc), .degrade_cause_o(degc),
      .upstream_fail_cause_o(ssfc), .remote_defect_cause_o(rdic),
      .outgoing_defect_cause_o(odic), .incoming_all_ones_cause_o(iac),
      .near_block_count_o(nbc), .far_block_count_o(fbc), .outgoing_near_block_count_o(onbc),
      .outgoing_far_block_count_o(ofbc), .near_defect_second_o(nds),
      .far_defect_second_o(fds), .outgoing_near_defect_second_o(onds),
      .outgoing_far_defect_second_o(ofds), .source_data_o(src_d), .source_fs_o(sfs),
      .adapted_fail_out_o(afo), .server_fail_action_o(ssfa),
      .adapt_all_ones_request_o(aar), .adapt_all_ones_active_o(aact), .adapt_data_o(ad_d));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   // the frame start that setb waits on still carries the old byte; the next one carries the new
   task automatic setb(input logic [7:0] b);
      @(posedge s_fs);
      nb = b;
   endtask
   task automatic wf(input int n);
      repeat (n) @(posedge s_fs);
      step(12);
   endtask
   task automatic pulse();
      sec = 1'b1;
      step(1);
      sec = 1'b0;
      step(2);
   endtask
   task automatic complete_run();
      if (n_fail == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      #200000;
      n_fail++;
      complete_run();
   end
   initial begin
      {uf, tim, oom, deg, rdi, odi, eqd, nbe, fbe, onbe, ofbe, mon, en, aen, sec, ofi} = '0;
      nb = 8'h35;
      reset_i = 1'b1;
      step(3);
      reset_i = 1'b0;
      step(4);
      check({ucz, timc, ssfc, rdic, odic, iac}, 6'b0);
      mon = 1'b1;
      aen = 1'b1;
      for (int v = 0; v < 16; v++) begin
         if (v != 14) begin
            setb({v[3:0], 4'h5});
            wf(5);
            check(incais, 1'b0);
         end
      end
      setb(8'hE5);
      wf(4);
      check(incais, 1'b0);
      wf(1);
      check({incais, oda, osf, req, tsf, iac}, 6'b111001);
      uf = 1'b1;
      step(3);
      check({iac, afo, tsf, ssfc}, 4'b0110);
      uf = 1'b0;
      setb(8'h15);
      wf(4);
      check(incais, 1'b1);
      wf(1);
      check(incais, 1'b0);
      setb(8'h00);
      wf(4);
      check(uneq, 1'b0);
      wf(1);
      check({uneq, req, tsf, rda, ucz, sink_d}, {5'b11111, `TCSDA_ALL_ONES_BYTE});
      tim = 1'b1;
      oom = 1'b1;
      step(8);
      check({tlc, timc, ucz}, 3'b001);
      {tim, oom} = 2'b00;
      setb(8'h35);
      wf(4);
      check(uneq, 1'b1);
      wf(1);
      check({uneq, req, sink_d[7]}, 3'b000);
      for (int k = 0; k < 128; k++) begin
         {en, odi, rdi, deg, oom, tim, uf} = k[6:0];
         step(8);
         e_tsf = uf | tim | oom;
         check({tl, req, tsf, rda, tsd, oda, osf, sink_d[7]},
            {oom, tim | oom, e_tsf, e_tsf, deg, e_tsf, e_tsf, tim | oom});
         check({tlc, timc, degc, ssfc, rdic, odic}, {oom, tim & !oom,
            deg & !tim & !oom, uf & en, rdi & en & !tim & !oom,
            odi & en & !tim & !oom});
      end
      mon = 1'b0;
      step(3);
      check({tlc, timc, degc, ssfc, rdic, odic}, 6'b0);
      {uf, tim, oom, deg, rdi, odi, en} = '0;
      step(8);
      pulse();
      @(posedge s_fs);
      step(1);
      {nbe, fbe, onbe, ofbe, eqd, rdi, odi} = '1;
      repeat (3) @(posedge s_fs);
      step(1);
      check({rea, oea}, 2'b11);
      {nbe, fbe, onbe, ofbe} = '0;
      pulse();
      check({nbc, fbc, onbc, ofbc}, {4{16'd3}});
      check({nds, fds, onds, ofds}, 4'hF);
      {eqd, rdi, odi} = '0;
      pulse();
      pulse();
      check({nbc, fbc, onbc, ofbc}, 64'h0);
      check({nds, fds, onds, ofds}, 4'h0);
      uf = 1'b1;
      @(posedge sfs);
      t0 = $time;
      step(3);
      check(src_d, `TCSDA_ALIGN_ONE);
      step(8);
      check(src_d, `TCSDA_ALIGN_TWO);
      step(8);
      check(src_d, `TCSDA_ALL_ONES_BYTE);
      @(posedge sfs);
      check($time - t0, 64'd512);
      step(1);
      uf = 1'b0;
      ofi = 1'b1;
      step(3);
      check({ssfa, aar, aact, ad_d}, {3'b111, `TCSDA_ALL_ONES_BYTE});
      ofi = 1'b0;
      step(3);
      check({ssfa, aar, aact}, 3'b000);
      complete_run();
   end
endmodule
